// ==== src/gpio_port.sv ====
`default_nettype none
module gpio_port (
  input wire logic CLK_I,
  input wire logic RSTN_I,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  output logic IRQ_O,
  input wire logic [4:0] PIN_I,
  output logic [4:0] PIN_O,
  output logic [4:0] PIN_OE_O,
  output logic [4:0] PULL_UP_O,
  output logic [4:0] PULL_DN_O,
  output logic [4:0] SLOW_O,
  input wire logic [4:0] DEF_OUT_I,
  input wire logic [4:0] DEF_OE_I,
  output logic [4:0] DEF_IN_O,
  output logic STORE_BOOT_O,
  input wire logic BOOT_VALID_I,
  input wire logic [59:0] BOOT_CFG_I,
  output logic [59:0] SAVE_CFG_O
);
  localparam int N = gpio_port_pkg::NUM_PINS;

  gpio_port_pkg::pin_cfg_t cfg [N];
  gpio_port_pkg::pin_stat_t stat [N];
  gpio_port_pkg::cmd_t cmd;
  logic [4:0] pin_m;
  logic [4:0] pin_s;
  logic [4:0] pin_prev;
  logic [20:0] smp_cnt;
  logic smp_tick;
  logic [12:0] pwm_div;
  logic [6:0] pwm_phase;
  logic go;
  logic [7:0] reply;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [7:0] query_idx;
  logic query_go;
  logic cmd_ok;
  logic boot_load;
  logic [2:0] next_events;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic gpio_port_pkg::pin_cfg_t def_cfg(input int i);
    logic [3:0] c;
    c = (i == 0) ? gpio_port_pkg::CFG_DEF_PIN0 :
        (i == 1) ? gpio_port_pkg::CFG_DEF_PIN1 :
        (i == 2) ? gpio_port_pkg::CFG_DEF_PIN2 :
        (i == 3) ? gpio_port_pkg::CFG_DEF_PIN3 :
        gpio_port_pkg::CFG_DEF_PIN4;
    def_cfg = {c, gpio_port_pkg::VALUE_DEF};
  endfunction : def_cfg

  function automatic logic valid_set(input gpio_port_pkg::cmd_t c);
    valid_set = (c.data0 < 8'(N)) && (c.data1 <= gpio_port_pkg::VALUE_HIGH)
      && (c.length == 2'd2 || (c.length == 2'd3
      && (c.data2 & gpio_port_pkg::CFG_RSVD_MASK) == 8'h00
      && c.data2[2:0] != gpio_port_pkg::MODE_RESERVED));
  endfunction : valid_set

  // ------------------------------------------------------------
  // Command port
  // ------------------------------------------------------------
  assign go = WR_I && ADDR_I == gpio_port_pkg::ADDR_CMD_GO;
  assign query_go = WR_I && ADDR_I == gpio_port_pkg::ADDR_QUERY;
  // Length rides on the go write itself, not the stale stored copy
  assign cmd_ok = cmd.cmd_type == gpio_port_pkg::CMD_SET_PIN
    && valid_set('{cmd.cmd_type, cmd.data0, cmd.data1, cmd.data2,
    WDATA_I[1:0]}); // see RULE_17

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cmd <= '0;
    end else if (WR_I) begin
      case (ADDR_I)
        gpio_port_pkg::ADDR_CMD_TYPE: cmd.cmd_type <= WDATA_I;
        gpio_port_pkg::ADDR_DATA0: cmd.data0 <= WDATA_I;
        gpio_port_pkg::ADDR_DATA1: cmd.data1 <= WDATA_I;
        gpio_port_pkg::ADDR_DATA2: cmd.data2 <= WDATA_I;
        gpio_port_pkg::ADDR_CMD_GO: cmd.length <= WDATA_I[1:0];
        default: ;
      endcase
    end
  end

  // Boot image loads one cycle after reset release, never under reset
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      boot_load <= 1'b1;
    end else begin
      boot_load <= 1'b0;
    end
  end

  // Configuration store; length arrives with the go write
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < N; i++) begin
        cfg[i] <= def_cfg(i); // see RULE_16
      end
    end else if (boot_load) begin
      if (BOOT_VALID_I) begin
        for (int i = 0; i < N; i++) begin
          cfg[i] <= BOOT_CFG_I[i*12 +: 12]; // see RULE_15
        end
      end
    end else if (go && cmd.cmd_type == gpio_port_pkg::CMD_SET_PIN
        && valid_set('{cmd.cmd_type, cmd.data0, cmd.data1, cmd.data2,
        WDATA_I[1:0]})) begin
      cfg[cmd.data0[2:0]].value <= cmd.data1; // see RULE_01
      if (WDATA_I[1:0] == 2'd3) begin
        cfg[cmd.data0[2:0]].func <= cmd.data2[gpio_port_pkg::CFG_FUNC_BIT];
        cfg[cmd.data0[2:0]].mode <= cmd.data2[2:0]; // see RULE_02, RULE_05
      end
    end
  end

  always_comb begin
    for (int i = 0; i < N; i++) begin
      SAVE_CFG_O[i*12 +: 12] = cfg[i]; // see RULE_15
    end
  end

  // Reply type and store-boot strobe
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      reply <= 8'h00;
      STORE_BOOT_O <= 1'b0;
    end else begin
      STORE_BOOT_O <= go && cmd.cmd_type == gpio_port_pkg::CMD_STORE_BOOT;
      if (go && cmd.cmd_type == gpio_port_pkg::CMD_SET_PIN
          && valid_set('{cmd.cmd_type, cmd.data0, cmd.data1, cmd.data2,
          WDATA_I[1:0]})) begin
        reply <= cmd.cmd_type | gpio_port_pkg::REPLY_FLAG; // see RULE_14
      end
    end
  end

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pwm_div <= '0;
      pwm_phase <= '0;
    end else if (pwm_div == 13'(gpio_port_pkg::PWM_TICK_CYCLES - 1)) begin
      pwm_div <= '0;
      pwm_phase <= (pwm_phase == 7'(gpio_port_pkg::PWM_STEPS - 1)) ?
        7'h00 : pwm_phase + 7'h01; // see RULE_04
    end else begin
      pwm_div <= pwm_div + 13'h0001;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      PIN_O <= '0;
      PIN_OE_O <= '0;
      PULL_UP_O <= '0;
      PULL_DN_O <= '0;
      SLOW_O <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        logic lvl;
        lvl = {1'b0, pwm_phase} < cfg[i].value; // see RULE_03, RULE_04
        if (!cfg[i].func) begin
          PIN_O[i] <= DEF_OUT_I[i]; // see RULE_10
          PIN_OE_O[i] <= DEF_OE_I[i];
          PULL_UP_O[i] <= cfg[i].mode == gpio_port_pkg::MODE_RES_UP_STRONG_DN;
          PULL_DN_O[i] <= 1'b0;
          SLOW_O[i] <= 1'b0;
        end else begin
          PIN_O[i] <= lvl; // see RULE_11
          PULL_UP_O[i] <= 1'b0;
          PULL_DN_O[i] <= 1'b0;
          SLOW_O[i] <= cfg[i].mode[2];
          case (cfg[i].mode)
            gpio_port_pkg::MODE_STRONG_UP_RES_DN: begin
              PIN_OE_O[i] <= lvl;
              PULL_DN_O[i] <= !lvl; // see RULE_06
            end
            gpio_port_pkg::MODE_STRONG_BOTH: PIN_OE_O[i] <= 1'b1;
            gpio_port_pkg::MODE_HIZ: PIN_OE_O[i] <= 1'b0; // see RULE_07
            gpio_port_pkg::MODE_RES_UP_STRONG_DN: begin
              PIN_OE_O[i] <= !lvl;
              PULL_UP_O[i] <= lvl; // see RULE_07
            end
            gpio_port_pkg::MODE_SLOW_UP_HIZ_DN: PIN_OE_O[i] <= lvl;
            gpio_port_pkg::MODE_SLOW_BOTH: PIN_OE_O[i] <= 1'b1; // see RULE_08
            gpio_port_pkg::MODE_HIZ_UP_SLOW_DN: PIN_OE_O[i] <= !lvl;
            default: PIN_OE_O[i] <= 1'b0; // see RULE_09
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Input sampling and edge latches
  // ------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_m <= '0;
      pin_s <= '0;
    end else begin
      pin_m <= PIN_I;
      pin_s <= pin_m;
    end
  end

  assign smp_tick = smp_cnt == 21'(gpio_port_pkg::SAMPLE_CYCLES - 1);
  assign DEF_IN_O = pin_prev;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      smp_cnt <= '0;
    end else begin
      smp_cnt <= smp_tick ? 21'h000000 : smp_cnt + 21'h000001; // see RULE_12
    end
  end

  // Edges only at sample ticks: short pulses between ticks are missed
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pin_prev <= '0;
      for (int i = 0; i < N; i++) begin
        stat[i] <= '0;
      end
    end else begin
      if (smp_tick) begin
        pin_prev <= pin_s; // see RULE_12
      end
      for (int i = 0; i < N; i++) begin
        if (smp_tick) begin
          stat[i].state <= pin_s[i];
        end
        if (query_go && WDATA_I == 8'(i)) begin
          stat[i].rise <= 1'b0; // see RULE_18
          stat[i].fall <= 1'b0;
        end
        if (smp_tick && pin_s[i] && !pin_prev[i]) begin
          stat[i].rise <= 1'b1; // see RULE_13
        end
        if (smp_tick && !pin_s[i] && pin_prev[i]) begin
          stat[i].fall <= 1'b1; // see RULE_13
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Interrupts and read port
  // ------------------------------------------------------------
  always_comb begin
    next_events = '0;
    next_events[gpio_port_pkg::IRQ_REPLY_BIT] = go && cmd_ok;
    next_events[gpio_port_pkg::IRQ_REJECT_BIT] = go
      && cmd.cmd_type == gpio_port_pkg::CMD_SET_PIN && !cmd_ok;
    next_events[gpio_port_pkg::IRQ_EDGE_BIT] = smp_tick && (pin_s != pin_prev);
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      irq_status <= '0;
      irq_mask <= '0;
      query_idx <= '0;
    end else begin
      if (query_go) begin
        query_idx <= WDATA_I;
      end
      if (WR_I && ADDR_I == gpio_port_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= WDATA_I[2:0];
      end
      // Set beats the write-one clear
      if (WR_I && ADDR_I == gpio_port_pkg::ADDR_IRQ_STATUS) begin
        irq_status <= (irq_status & ~WDATA_I[2:0]) | next_events;
      end else begin
        irq_status <= irq_status | next_events;
      end
    end
  end

  assign IRQ_O = |(irq_status & irq_mask);

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= '0;
    end else if (RD_I) begin
      case (ADDR_I)
        gpio_port_pkg::ADDR_CMD_TYPE: RDATA_O <= cmd.cmd_type;
        gpio_port_pkg::ADDR_DATA0: RDATA_O <= cmd.data0;
        gpio_port_pkg::ADDR_DATA1: RDATA_O <= cmd.data1;
        gpio_port_pkg::ADDR_DATA2: RDATA_O <= cmd.data2;
        gpio_port_pkg::ADDR_REPLY: RDATA_O <= reply;
        gpio_port_pkg::ADDR_IRQ_STATUS: RDATA_O <= {5'h00, irq_status};
        gpio_port_pkg::ADDR_IRQ_MASK: RDATA_O <= {5'h00, irq_mask};
        gpio_port_pkg::ADDR_QUERY: begin
          if (query_idx < 8'(N)) begin
            RDATA_O <= {5'h00, stat[query_idx[2:0]]}; // see RULE_13
          end else begin
            RDATA_O <= 8'h00;
          end
        end
        default: RDATA_O <= 8'h00;
      endcase
    end else begin
      RDATA_O <= '0;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_reply_type: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    go && cmd_ok |=> reply == 8'h62) // see RULE_14
    else $error("reply type wrong after set");
  a_bad_index_kept: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    go && cmd.data0 >= 8'(N) |=> $stable(cfg[0]) && $stable(cfg[4])) // see RULE_17
    else $error("reserved index changed a pin");
  a_mode_hiz: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg[0].func && cfg[0].mode == gpio_port_pkg::MODE_HIZ && $stable(cfg[0])
    |=> !PIN_OE_O[0]) // see RULE_07
    else $error("input mode drove the pin");
  a_strong_both: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg[1].func && cfg[1].mode == gpio_port_pkg::MODE_STRONG_BOTH
    && $stable(cfg[1]) |=> PIN_OE_O[1]) // see RULE_06
    else $error("strong mode not driving");
  a_value_high: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg[2].func && cfg[2].value == gpio_port_pkg::VALUE_HIGH |=> PIN_O[2])
    // see RULE_03
    else $error("value 100 not high");
  a_value_low: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg[2].func && cfg[2].value == 8'h00 |=> !PIN_O[2]) // see RULE_03
    else $error("value 0 not low");
  a_rise_latch: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    smp_tick && pin_s[0] && !pin_prev[0] |=> stat[0].rise) // see RULE_13
    else $error("rising edge not latched");
  a_query_clear: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    query_go && WDATA_I == 8'h03 && !smp_tick |=> !stat[3].fall) // see RULE_18
    else $error("query did not clear");
  a_slow_mode: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    cfg[4].func && cfg[4].mode == gpio_port_pkg::MODE_SLOW_BOTH
    && $stable(cfg[4]) |=> SLOW_O[4] && PIN_OE_O[4]) // see RULE_08
    else $error("slow drive not applied");
  a_default_func: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
    !cfg[3].func |=> PIN_OE_O[3] == $past(DEF_OE_I[3])) // see RULE_10
    else $error("default function not routed");
endmodule : gpio_port
`default_nettype wire

// ==== pkg/gpio_port_pkg.sv ====
// Operation
// RULE_01 - Five pins, selected by index 0 to 4; higher indices are reserved.
// RULE_02 - Set command has two bytes (value only) or three (value plus config).
// RULE_03 - Output value 0 drives low, 100 drives high, above 100 invalid.
// RULE_04 - Values 1 to 99 give 100 Hz PWM with that percent high time.
// RULE_05 - Config byte is 0 to 15: function bit 3, drive mode bits 2..0.
// RULE_06 - Mode 000 strong up, resistive down; 001 strong both ways.
// RULE_07 - Mode 010 high impedance; 011 resistive up, strong down.
// RULE_08 - Mode 100 slow strong up, float low; 101 slow strong both ways.
// RULE_09 - Mode 110 reserved; 111 floats a one, slow strong drive down.
// RULE_10 - Function bit clear hands the pin to its default function.
// RULE_11 - Function bit set puts the pin under user value and drive mode.
// RULE_12 - Every pin is sampled as an input at 32 Hz continuously.
// RULE_13 - Per pin, latch rising and falling edges seen since last query.
// RULE_14 - After a set command type 0x22 reply with type 0x62, no data.
// RULE_15 - Whole pin configuration saved on store-boot, restored at power-up.
// RULE_16 - Factory default: pins 1..4 power sense, power, reset, one-wire.
// RULE_17 - Set commands with bad index, value or reserved bits are ignored.
// RULE_18 - A query clears the queried pin's rising and falling indications.
`default_nettype none
package gpio_port_pkg;
  localparam int NUM_PINS = 5;
  localparam int CLK_HZ = 40000000;
  localparam int PWM_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int SAMPLE_HZ = 32;
  localparam int PWM_TICK_CYCLES = CLK_HZ / (PWM_HZ * PWM_STEPS);
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
  localparam logic [7:0] CMD_SET_PIN = 8'h22;
  localparam logic [7:0] CMD_QUERY_PIN = 8'h23;
  localparam logic [7:0] CMD_STORE_BOOT = 8'h04;
  localparam logic [7:0] REPLY_FLAG = 8'h40;
  localparam logic [7:0] VALUE_HIGH = 8'h64;
  localparam int CFG_FUNC_BIT = 3;
  localparam logic [7:0] CFG_RSVD_MASK = 8'hf0;
  localparam logic [2:0] MODE_STRONG_UP_RES_DN = 3'h0;
  localparam logic [2:0] MODE_STRONG_BOTH = 3'h1;
  localparam logic [2:0] MODE_HIZ = 3'h2;
  localparam logic [2:0] MODE_RES_UP_STRONG_DN = 3'h3;
  localparam logic [2:0] MODE_SLOW_UP_HIZ_DN = 3'h4;
  localparam logic [2:0] MODE_SLOW_BOTH = 3'h5;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [2:0] MODE_HIZ_UP_SLOW_DN = 3'h7;
  // Factory configuration bytes per pin, pin 0 first
  localparam logic [3:0] CFG_DEF_PIN0 = 4'h0;
  localparam logic [3:0] CFG_DEF_PIN1 = 4'h3;
  localparam logic [3:0] CFG_DEF_PIN2 = 4'h2;
  localparam logic [3:0] CFG_DEF_PIN3 = 4'h2;
  localparam logic [3:0] CFG_DEF_PIN4 = 4'h0;
  localparam logic [7:0] VALUE_DEF = 8'h00;
  // Register map of the plain register port
  localparam logic [3:0] ADDR_CMD_TYPE = 4'h0;
  localparam logic [3:0] ADDR_DATA0 = 4'h1;
  localparam logic [3:0] ADDR_DATA1 = 4'h2;
  localparam logic [3:0] ADDR_DATA2 = 4'h3;
  localparam logic [3:0] ADDR_CMD_GO = 4'h4;
  localparam logic [3:0] ADDR_REPLY = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h7;
  localparam logic [3:0] ADDR_QUERY = 4'h8;
  localparam int IRQ_REPLY_BIT = 0;
  localparam int IRQ_EDGE_BIT = 1;
  localparam int IRQ_REJECT_BIT = 2;

  typedef struct packed {
    logic func;
    logic [2:0] mode;
    logic [7:0] value;
  } pin_cfg_t;

  typedef struct packed {
    logic rise;
    logic fall;
    logic state;
  } pin_stat_t;

  typedef struct packed {
    logic [7:0] cmd_type;
    logic [7:0] data0;
    logic [7:0] data1;
    logic [7:0] data2;
    logic [1:0] length;
  } cmd_t;
endpackage : gpio_port_pkg
`default_nettype wire

// ==== verification/gpio_pin_load.sv ====
`default_nettype none
// ----------------------------------------
// Pin load seen from outside the pins
// ----------------------------------------
module gpio_pin_load (
  input wire logic clk_i,
  input wire logic [4:0] drv_i,
  input wire logic [4:0] oe_i,
  input wire logic [4:0] pull_up_i,
  input wire logic [4:0] pull_dn_i,
  input wire logic [4:0] ext_en_i,
  input wire logic [4:0] ext_lvl_i,
  output logic [4:0] level_o
);
  logic [4:0] last;

  // Undriven pins toggle so a missing drive never reads as a clean level
  always_ff @(posedge clk_i) begin
    last <= level_o;
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (oe_i[i]) begin
        level_o[i] = drv_i[i];
      end else if (ext_en_i[i]) begin
        level_o[i] = ext_lvl_i[i];
      end else if (pull_up_i[i] != pull_dn_i[i]) begin
        level_o[i] = pull_up_i[i];
      end else begin
        level_o[i] = ~last[i];
      end
    end
  end
endmodule : gpio_pin_load
`default_nettype wire

// ==== verification/gpio_set_configure_port_tb.sv ====
`default_nettype none
module gpio_set_configure_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, wr_en, rd_en, irq, store_boot, boot_valid;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [4:0] pin_in, pin_out, pin_oe, pull_up, pull_dn, slow;
  logic [4:0] def_out, def_oe, ext_en, ext_lvl, e;
  logic [59:0] boot_cfg, save_cfg;
  logic [11:0] cfg [5];
  int mismatches, cmp_count, seed, p, seen;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  gpio_port dut (.CLK_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr_en), .RD_I(rd_en), .RDATA_O(rdata), .IRQ_O(irq),
    .PIN_I(pin_in), .PIN_O(pin_out), .PIN_OE_O(pin_oe), .PULL_UP_O(pull_up),
    .PULL_DN_O(pull_dn), .SLOW_O(slow), .DEF_OUT_I(def_out),
    .DEF_OE_I(def_oe), .DEF_IN_O(), .STORE_BOOT_O(store_boot),
    .BOOT_VALID_I(boot_valid), .BOOT_CFG_I(boot_cfg), .SAVE_CFG_O(save_cfg));

  gpio_pin_load load (.clk_i(clk), .drv_i(pin_out), .oe_i(pin_oe),
    .pull_up_i(pull_up), .pull_dn_i(pull_dn), .ext_en_i(ext_en),
    .ext_lvl_i(ext_lvl), .level_o(pin_in));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [59:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  function automatic logic [59:0] exp_save();
    for (int i = 0; i < 5; i++) begin
      exp_save[i*12+:12] = cfg[i];
    end
  endfunction : exp_save

  // Result is {oe, out, pull_up, pull_dn, slow}
  function automatic logic [4:0] drive(input logic [2:0] m, input logic b);
    case (m)
      3'h0: return b ? 5'b11000 : 5'b00010;
      3'h1: return {1'b1, b, 3'b000};
      3'h3: return b ? 5'b00100 : 5'b10000;
      3'h4: return b ? 5'b11001 : 5'b00000;
      3'h5: return {1'b1, b, 3'b001};
      3'h7: return b ? 5'b00000 : 5'b10001;
      default: return 5'b00000;
    endcase
  endfunction : drive

  task automatic chk_pin(input int i, input logic [4:0] x);
    logic [4:0] a;
    a = {pin_oe[i], pin_out[i], pull_up[i], pull_dn[i], slow[i]};
    // Level and slew mean nothing while the pin is released
    if (x[4] !== 1'b1) a = a & 5'b10110;
    chk(a, x, "pin drive");
  endtask : chk_pin

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic set(input logic [7:0] i, v, c, input logic [1:0] n);
    bus_wr(4'h0, gpio_port_pkg::CMD_SET_PIN);
    bus_wr(4'h1, i);
    bus_wr(4'h2, v);
    bus_wr(4'h3, c);
    bus_wr(4'h4, {6'h0, n});
    // Bad index, value or reserved bits leave the model untouched
    if (i < 5 && v <= 8'd100 && (n == 2'd2 || c < 8'd16)) begin
      cfg[i] = (n == 2'd3) ? {c[3:0], v} : {cfg[i][11:8], v};
    end
    repeat (3) @(posedge clk);
    #1;
  endtask : set

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    seed = 32'hfa70;
    {rstn, wr_en, rd_en, boot_valid} = 4'h0;
    {addr, wdata, boot_cfg} = '0;
    def_out = 5'h00;
    def_oe = 5'h00;
    ext_en = 5'h00;
    ext_lvl = 5'h00;
    cfg = '{12'h000, 12'h300, 12'h200, 12'h200, 12'h000};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    ext_en <= $random(seed);
    ext_lvl <= $random(seed);
    repeat (2) @(posedge clk);
    #1;
    chk(save_cfg, exp_save(), "factory config");
    bus_wr(4'h7, 8'h01);
    set(8'h0, 8'd100, 8'h09, 2'd3);
    bus_rd(4'h5);
    chk(d, 8'h62, "reply type");
    chk(irq, 1'b1, "irq on reply");
    bus_wr(4'h6, 8'h01);
    @(posedge clk);
    #1;
    chk(irq, 1'b0, "irq cleared");
    for (int m = 0; m < 8; m++) begin
      for (int b = 0; b < 2; b++) begin
        if (m == 6) continue;
        p = {$random(seed)} % 5;
        set(p[7:0], b ? 8'd100 : 8'd0, {5'h01, m[2:0]}, 2'd3);
        chk_pin(p, drive(m[2:0], b[0]));
        set(p[7:0], b ? 8'd0 : 8'd100, 8'hff, 2'd2);
        chk_pin(p, drive(m[2:0], !b[0]));
        chk(save_cfg, exp_save(), "saved config");
      end
    end
    bus_rd(4'h6);
    chk(d[0], 1'b1, "reply status");
    bus_wr(4'h7, 8'h00);
    #1;
    chk(irq, 1'b0, "masked irq");
    set(8'h5, 8'd100, 8'h09, 2'd3);
    set(p[7:0], 8'd101, 8'h09, 2'd3);
    set(p[7:0], 8'd0, 8'h19, 2'd3);
    chk(save_cfg, exp_save(), "ignored set");
    bus_rd(4'h6);
    chk(d[2], 1'b1, "reject status");
    def_oe <= 5'h1f;
    def_out <= $random(seed);
    set(p[7:0], 8'd0, 8'h01, 2'd3);
    chk({pin_oe[p], pin_out[p]}, {1'b1, def_out[p]}, "default");
    bus_wr(4'h8, p[7:0]);
    bus_rd(4'h8);
    chk(d[7:1], 7'h00, "edge flags");
    for (int a = 9; a < 16; a++) begin
      bus_rd(a[3:0]);
      chk(d, 8'h00, "unmapped read");
    end
    bus_wr(4'h0, gpio_port_pkg::CMD_STORE_BOOT);
    bus_wr(4'h4, 8'h00);
    seen = 0;
    repeat (4) begin
      #1 if (store_boot === 1'b1) seen++;
      @(posedge clk);
    end
    chk(seen, 1, "store pulse");
    for (int i = 0; i < 5; i++) begin
      p = {$random(seed)} % 100;
      cfg[i] = {1'b1, (i == 1) ? 3'h7 : i[2:0], p[7:0]};
      boot_cfg[i*12+:12] = cfg[i];
    end
    rstn <= 1'b0;
    boot_valid <= 1'b1;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(save_cfg, exp_save(), "boot restore");
    tally_and_finish;
  end
endmodule : gpio_set_configure_port_tb
`default_nettype wire
